// ### pdc_defines.vh
/*
 power-down sequencer and configuration mode decoder constants.
 assumes a 100 MHz system clock; included by pdc_power_down_ctrl.v.
*/
`ifndef PDC_DEFINES_VH
`define PDC_DEFINES_VH

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define PDC_CLK_PERIOD_NS 10
`define PDC_STAGE_GAP_NS 10
// longest-time figure rounds down, never below one cycle
`define PDC_STAGE_GAP_CYC ((`PDC_STAGE_GAP_NS / `PDC_CLK_PERIOD_NS) < 1 ? 1 : \
	(`PDC_STAGE_GAP_NS / `PDC_CLK_PERIOD_NS))
// gap counter width; only the low bits of the cycle figure are ever used
`define PDC_CNT_W 4

// -----------------------------------------------------------------------------
// configuration mode encodings
// -----------------------------------------------------------------------------
`define PDC_MODE_W 2
`define PDC_MODE_SLAVE_SERIAL 2'h0
`define PDC_MODE_MASTER_SERIAL 2'h1
`define PDC_MODE_EXPRESS 2'h2

// -----------------------------------------------------------------------------
// sequencer state codes
// -----------------------------------------------------------------------------
`define PDC_ST_W 3
`define PDC_ST_RUN 3'h0
`define PDC_ST_ENTER 3'h1
`define PDC_ST_DOWN 3'h2
`define PDC_ST_EXIT 3'h3

`endif

// ### pdc_power_down_ctrl.v
/*
 power-down sequencer and configuration mode control for the device core.
 assumes power_down_n, mode pins and program arrive asynchronously from
 board logic; config_done and scan_extest come from core logic on clk.
 limitation: power-down pulses shorter than one clock may be missed;
 the board is expected to keep them far longer than that.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pdc_defines.vh"

module pdc_power_down_ctrl (
	// clock and reset
	input wire clk,
	input wire rst,
	// board pins (asynchronous)
	input wire power_down_n,
	input wire mode_select_upper,
	input wire mode_select_lower,
	input wire program_n,
	input wire configuration_clock,
	input wire done_pin,
	// core-side controls
	input wire two_pin_variant,
	input wire config_start,
	input wire config_done,
	input wire user_float_req,
	input wire user_set_reset_req,
	input wire scan_extest,
	input wire init_status_in,
	// pin views seen by the core, all gated except program
	output reg mode_upper_seen_ff,
	output reg mode_lower_seen_ff,
	output reg configuration_clock_seen_ff,
	output reg done_seen_ff,
	output reg program_seen_n_ff,
	// buffer and global net controls
	output reg input_buf_en_ff,
	output reg output_buf_en_ff,
	output reg pullup_en_ff,
	output reg mode_pullup_en_ff,
	output reg global_set_reset_ff,
	output reg global_output_float_ff,
	output reg scan_enable_ff,
	// configuration control and status
	output reg config_restart_ff,
	output reg [`PDC_MODE_W-1:0] config_mode_ff,
	output reg mode_valid_ff,
	output reg init_status_ff,
	output reg init_status_oe_ff,
	output reg powered_down_ff
);

// -----------------------------------------------------------------------------
// helpers
// -----------------------------------------------------------------------------
// map pin levels to a configuration mode code
function [`PDC_MODE_W-1:0] pdc_decode_mode;
	input two_pin;
	input upper;
	input lower;
	begin
		// single-pin variant reads only the lower pin
		if (!two_pin) begin
			pdc_decode_mode = lower ? `PDC_MODE_SLAVE_SERIAL : `PDC_MODE_MASTER_SERIAL;
		end else if (!upper) begin
			pdc_decode_mode = `PDC_MODE_EXPRESS;
		end else begin
			pdc_decode_mode = lower ? `PDC_MODE_SLAVE_SERIAL : `PDC_MODE_MASTER_SERIAL;
		end
	end
endfunction

// -----------------------------------------------------------------------------
// input synchronisers
// -----------------------------------------------------------------------------
reg [1:0] pwr_sync_ff;
reg [1:0] upper_sync_ff;
reg [1:0] lower_sync_ff;
reg [1:0] prog_sync_ff;
reg [1:0] cfg_clk_sync_ff;
reg [1:0] done_sync_ff;

// two flops per pin; reset assumes pull-ups, so power-down reads inactive
always @(posedge clk) begin
	if (rst) begin
		pwr_sync_ff <= 2'h3;
		upper_sync_ff <= 2'h3;
		lower_sync_ff <= 2'h3;
		prog_sync_ff <= 2'h3;
		cfg_clk_sync_ff <= 2'h0;
		done_sync_ff <= 2'h0;
	end else begin
		pwr_sync_ff <= {pwr_sync_ff[0], power_down_n};
		upper_sync_ff <= {upper_sync_ff[0], mode_select_upper};
		lower_sync_ff <= {lower_sync_ff[0], mode_select_lower};
		prog_sync_ff <= {prog_sync_ff[0], program_n};
		cfg_clk_sync_ff <= {cfg_clk_sync_ff[0], configuration_clock};
		done_sync_ff <= {done_sync_ff[0], done_pin};
	end
end

wire pwr_req = ~pwr_sync_ff[1];
// only the second flop is read, so no logic sees a metastable level

// -----------------------------------------------------------------------------
// power-down sequencer
// -----------------------------------------------------------------------------
reg [`PDC_ST_W-1:0] state_ff;
reg [`PDC_ST_W-1:0] nxt_state;
reg [`PDC_CNT_W-1:0] gap_cnt_ff;
reg [`PDC_CNT_W-1:0] nxt_gap_cnt;
reg in_en_ff;
reg nxt_in_en;
reg out_en_ff;
reg nxt_out_en;
reg pd_set_reset_ff;
reg nxt_pd_set_reset;

// gap length in cycles minus one, sliced on purpose to the counter width
localparam integer GAP_LAST_INT = `PDC_STAGE_GAP_CYC - 1;
localparam [`PDC_CNT_W-1:0] GAP_LAST = GAP_LAST_INT[`PDC_CNT_W-1:0];

// next-state logic; a release mid-entry still walks through the exit gap
always @* begin
	nxt_state = state_ff;
	nxt_gap_cnt = gap_cnt_ff;
	nxt_in_en = in_en_ff;
	nxt_out_en = out_en_ff;
	nxt_pd_set_reset = pd_set_reset_ff;
	// every state holds its enables unless a stage moves
	case (state_ff)
		`PDC_ST_RUN: begin
			if (pwr_req) begin
				// inputs and set/reset go together, outputs wait one gap
				nxt_in_en = 1'b0;
				nxt_pd_set_reset = 1'b1;
				nxt_gap_cnt = {`PDC_CNT_W{1'b0}};
				nxt_state = `PDC_ST_ENTER;
			end
		end
		`PDC_ST_ENTER: begin
			if (gap_cnt_ff == GAP_LAST) begin
				nxt_out_en = 1'b0;
				nxt_state = `PDC_ST_DOWN;
			end else begin
				nxt_gap_cnt = gap_cnt_ff + 1'b1;
			end
		end
		`PDC_ST_DOWN: begin
			if (!pwr_req) begin
				nxt_in_en = 1'b1;
				// mirror order: inputs back first, outputs after the gap
				nxt_pd_set_reset = 1'b0;
				nxt_gap_cnt = {`PDC_CNT_W{1'b0}};
				nxt_state = `PDC_ST_EXIT;
			end
		end
		`PDC_ST_EXIT: begin
			if (pwr_req) begin
				// re-entry during the exit gap restarts the entry order
				nxt_in_en = 1'b0;
				nxt_pd_set_reset = 1'b1;
				nxt_gap_cnt = {`PDC_CNT_W{1'b0}};
				nxt_state = `PDC_ST_ENTER;
			end else if (gap_cnt_ff == GAP_LAST) begin
				nxt_out_en = 1'b1;
				nxt_state = `PDC_ST_RUN;
			end else begin
				nxt_gap_cnt = gap_cnt_ff + 1'b1;
			end
		end
		default: begin
			nxt_state = `PDC_ST_RUN;
			nxt_in_en = 1'b1;
			// unused codes fall back to normal running
			nxt_out_en = 1'b1;
			nxt_pd_set_reset = 1'b0;
		end
	endcase
end

// sequencer registers
always @(posedge clk) begin
	if (rst) begin
		state_ff <= `PDC_ST_RUN;
		gap_cnt_ff <= {`PDC_CNT_W{1'b0}};
		in_en_ff <= 1'b1;
		out_en_ff <= 1'b1;
		pd_set_reset_ff <= 1'b0;
	end else begin
		state_ff <= nxt_state;
		gap_cnt_ff <= nxt_gap_cnt;
		in_en_ff <= nxt_in_en;
		out_en_ff <= nxt_out_en;
		pd_set_reset_ff <= nxt_pd_set_reset;
	end
end

// -----------------------------------------------------------------------------
// configuration tracking and mode capture
// -----------------------------------------------------------------------------
// configured_ff never clears: configuration memory survives power-down
reg configured_ff;
reg pd_before_done_ff;

// a power-down before done drops config and asks for a restart on release
always @(posedge clk) begin
	if (rst) begin
		configured_ff <= 1'b0;
		pd_before_done_ff <= 1'b0;
		config_restart_ff <= 1'b0;
		config_mode_ff <= `PDC_MODE_SLAVE_SERIAL;
		mode_valid_ff <= 1'b0;
	end else begin
		config_restart_ff <= 1'b0;
		// the set branch wins over the release branch in one cycle
		if (pd_set_reset_ff && !configured_ff) begin
			pd_before_done_ff <= 1'b1;
			mode_valid_ff <= 1'b0;
		end else if (state_ff == `PDC_ST_EXIT && nxt_state == `PDC_ST_RUN) begin
			config_restart_ff <= pd_before_done_ff;
			pd_before_done_ff <= 1'b0;
		end else if (config_start && !mode_valid_ff && in_en_ff) begin
			// sampled once; ignored after configuration finishes
			config_mode_ff <= pdc_decode_mode(two_pin_variant, upper_sync_ff[1],
				lower_sync_ff[1]);
			mode_valid_ff <= 1'b1;
		end
		// done only counts while power-down does not hold the flops in set/reset
		if (config_done && !pd_set_reset_ff) begin
			configured_ff <= 1'b1;
		end
	end
end

// -----------------------------------------------------------------------------
// output stage
// -----------------------------------------------------------------------------
// all outputs registered; combinational core logic keeps running on lows
always @(posedge clk) begin
	if (rst) begin
		mode_upper_seen_ff <= 1'b0;
		mode_lower_seen_ff <= 1'b0;
		configuration_clock_seen_ff <= 1'b0;
		done_seen_ff <= 1'b0;
		program_seen_n_ff <= 1'b1;
		input_buf_en_ff <= 1'b1;
		output_buf_en_ff <= 1'b1;
		pullup_en_ff <= 1'b1;
		mode_pullup_en_ff <= 1'b1;
		global_set_reset_ff <= 1'b0;
		global_output_float_ff <= 1'b0;
		scan_enable_ff <= 1'b1;
		init_status_ff <= 1'b0;
		init_status_oe_ff <= 1'b0;
		powered_down_ff <= 1'b0;
	end else begin
		mode_upper_seen_ff <= in_en_ff & upper_sync_ff[1];
		mode_lower_seen_ff <= in_en_ff & lower_sync_ff[1];
		configuration_clock_seen_ff <= in_en_ff & cfg_clk_sync_ff[1];
		done_seen_ff <= in_en_ff & done_sync_ff[1];
		// program bypasses the gating so a reload can always be requested
		program_seen_n_ff <= prog_sync_ff[1];
		input_buf_en_ff <= in_en_ff;
		output_buf_en_ff <= out_en_ff & ~user_float_req;
		pullup_en_ff <= in_en_ff;
		mode_pullup_en_ff <= in_en_ff & ~configured_ff;
		// power-down and user request share one global set/reset net
		global_set_reset_ff <= pd_set_reset_ff | user_set_reset_req;
		// float ignored while scan drives pins in external test
		global_output_float_ff <= (~out_en_ff | user_float_req) &
			~(scan_extest & in_en_ff);
		scan_enable_ff <= in_en_ff;
		// status stays quiet from a power-down that hit an unfinished load until its release completes
		init_status_ff <= init_status_in & ~pd_before_done_ff & ~pd_set_reset_ff;
		init_status_oe_ff <= ~configured_ff & ~pd_before_done_ff & ~pd_set_reset_ff;
		powered_down_ff <= (state_ff != `PDC_ST_RUN);
	end
end

endmodule
`default_nettype wire

// ### pdc_monitor.sv
/*
 port-level checker for the power-down sequencer.
 assumes one clk domain, synchronous active-high rst; bound in the testbench.
*/
`timescale 1ns/1ns
`default_nettype none
module pdc_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// board-side inputs plus the core-side user set/reset request
	input wire logic power_down_n,
	input wire logic program_n,
	input wire logic user_set_reset_req,
	// core-side outputs
	input wire logic mode_upper_seen_ff,
	input wire logic configuration_clock_seen_ff,
	input wire logic done_seen_ff,
	input wire logic program_seen_n_ff,
	input wire logic input_buf_en_ff,
	input wire logic output_buf_en_ff,
	input wire logic pullup_en_ff,
	input wire logic global_set_reset_ff,
	input wire logic scan_enable_ff,
	input wire logic config_restart_ff
);
	// one domain, so one clocking and one disable
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_entry_order;
		$fell(input_buf_en_ff) |-> global_set_reset_ff ##1 !output_buf_en_ff;
	endproperty
	a_entry_order: assert property (p_entry_order) else $error("entry order wrong");
	property p_exit_order;
		$rose(input_buf_en_ff) && !user_set_reset_req |-> !global_set_reset_ff ##1 output_buf_en_ff;
	endproperty
	a_exit_order: assert property (p_exit_order) else $error("exit order wrong");
	// 2-flop sync, sequencer stage and output register set the latency
	property p_down_latency;
		$fell(power_down_n) ##1 !power_down_n [*5] |-> !input_buf_en_ff && global_set_reset_ff;
	endproperty
	a_down_latency: assert property (p_down_latency) else $error("inputs not disabled");
	property p_held_set_reset;
		!input_buf_en_ff |-> global_set_reset_ff;
	endproperty
	a_held_set_reset: assert property (p_held_set_reset) else $error("set/reset dropped");
	property p_gated_views;
		!input_buf_en_ff |-> !(mode_upper_seen_ff | configuration_clock_seen_ff |
			done_seen_ff | pullup_en_ff);
	endproperty
	a_gated_views: assert property (p_gated_views) else $error("input not forced low");
	property p_program_live;
		!program_n [*5] |-> !program_seen_n_ff;
	endproperty
	a_program_live: assert property (p_program_live) else $error("program gated");
	property p_scan_off;
		!input_buf_en_ff |-> !scan_enable_ff;
	endproperty
	a_scan_off: assert property (p_scan_off) else $error("scan usable while down");
	property p_restart_pulse;
		config_restart_ff |-> $rose(input_buf_en_ff) ##1 !config_restart_ff;
	endproperty
	a_restart_pulse: assert property (p_restart_pulse) else $error("restart misplaced");
	c_entry: cover property ($fell(input_buf_en_ff));
	c_exit: cover property ($rose(output_buf_en_ff));
	c_restart: cover property (config_restart_ff);
endmodule
`default_nettype wire

// ### pdc_board_model.sv
/*
 board logic model: power-down pin, mode pins and configuration clock.
 assumes the testbench requests power-down only through pd_req.
*/
`timescale 1ns/1ns
`default_nettype none
module pdc_board_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// requests from the bench
	input wire logic pd_req,
	input wire logic cfg_busy,
	input wire logic [1:0] mode_req,
	// board pins
	output var logic power_down_n,
	output wire logic mode_select_upper,
	output wire logic mode_select_lower,
	output var logic configuration_clock,
	output wire logic ready
);
	logic [3:0] hold_ff;
	// counter keeps the pulse and settle times well above 50 ns
	always @(posedge clk) begin
		if (rst) begin
			power_down_n <= 1'b1;
			hold_ff <= 4'h0;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
		end else if (!power_down_n) begin
			power_down_n <= 1'b1;
			hold_ff <= 4'h6;
		end else if (pd_req && !cfg_busy) begin
			power_down_n <= 1'b0;
			hold_ff <= 4'h8;
		end
	end
	// clock only runs during configuration
	always @(posedge clk) begin
		configuration_clock <= !rst && cfg_busy && !configuration_clock;
	end
	assign mode_select_upper = mode_req[1];
	assign mode_select_lower = mode_req[0];
	assign ready = power_down_n && hold_ff == 4'h0;
endmodule
`default_nettype wire

// ### test_power_down_and_config_mode_control.sv
/*
 self-checking testbench for the power-down sequencer and mode decoder.
 assumes pdc_board_model drives the power-down, mode and clock pins; checker bound below.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module test_power_down_and_config_mode_control;
	logic clk = 0, rst = 1, pd_req = 0, cfg_busy = 0, program_n = 1, done_pin = 1;
	logic two_pin_variant = 0, config_start = 0, config_done = 0, user_float_req = 0;
	logic user_set_reset_req = 0, scan_extest = 0, init_status_in = 1;
	logic [1:0] mode_req = 2'h3;
	logic power_down_n, mode_select_upper, mode_select_lower, configuration_clock, ready;
	logic mode_upper_seen_ff, mode_lower_seen_ff, configuration_clock_seen_ff, done_seen_ff;
	logic program_seen_n_ff, input_buf_en_ff, output_buf_en_ff, pullup_en_ff;
	logic mode_pullup_en_ff, global_set_reset_ff, global_output_float_ff, scan_enable_ff;
	logic config_restart_ff, mode_valid_ff, init_status_ff, init_status_oe_ff, powered_down_ff;
	logic [1:0] config_mode_ff;
	// {two_pin, upper, lower, expected mode}
	logic [4:0] tbl [6] = '{5'h04, 5'h09, 5'h19, 5'h12, 5'h16, 5'h1c};
	int fails = 0, total_checks = 0;
	pdc_power_down_ctrl u_dut (.*);
	pdc_board_model u_board (.*);
	always #5 clk = ~clk;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// bounded wait, sampled mid-cycle
	task automatic wait_en(logic v);
		for (int i = 0; i < 30 && input_buf_en_ff !== v; i++) @(negedge clk);
	endtask
	task automatic power_cycle(logic fin);
		@(posedge clk);
		pd_req <= 1'b1;
		program_n <= 1'b0;
		@(posedge clk);
		pd_req <= 1'b0;
		wait_en(1'b0);
		`CHK("out_gap", 1'b1, output_buf_en_ff)
		`CHK("setrst_on", 1'b1, global_set_reset_ff)
		`CHK("seen_low", 1'b0, mode_upper_seen_ff | mode_lower_seen_ff | done_seen_ff)
		@(negedge clk);
		`CHK("out_off", 1'b0, output_buf_en_ff)
		`CHK("float_on", 1'b1, global_output_float_ff)
		`CHK("down_flag", 1'b1, powered_down_ff)
		`CHK("prog_live", 1'b0, program_seen_n_ff)
		`CHK("init_quiet", 1'b0, init_status_oe_ff & ~fin)
		`CHK("init_off", 1'b0, init_status_ff)
		@(posedge clk);
		program_n <= 1'b1;
		wait_en(1'b1);
		`CHK("setrst_off", 1'b0, global_set_reset_ff)
		`CHK("out_lag", 1'b0, output_buf_en_ff)
		`CHK("restart", ~fin, config_restart_ff)
		@(negedge clk);
		`CHK("out_on", 1'b1, output_buf_en_ff)
		`CHK("restart_end", 1'b0, config_restart_ff)
		`CHK("up_flag", 1'b0, powered_down_ff)
		for (int i = 0; i < 20 && !ready; i++) @(negedge clk);
		`CHK("ready", 1'b1, ready)
	endtask
	task automatic mode_case(logic [4:0] c);
		power_cycle(config_done);
		@(posedge clk);
		two_pin_variant <= c[4];
		mode_req <= c[3:2];
		repeat (4) @(posedge clk);
		config_start <= 1'b1;
		cfg_busy <= 1'b1;
		@(posedge clk);
		config_start <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("mode", {1'b1, c[1:0]}, {mode_valid_ff, config_mode_ff})
		`CHK("mode_pu", 1'b1, mode_pullup_en_ff)
		`CHK("seen_pins", c[3:2], {mode_upper_seen_ff, mode_lower_seen_ff})
		@(posedge clk);
		cfg_busy <= 1'b0;
	endtask
	// after completion the pins no longer steer the mode
	task automatic keep_mode;
		@(posedge clk);
		config_done <= 1'b1;
		mode_req <= 2'h0;
		repeat (4) @(posedge clk);
		config_start <= 1'b1;
		@(posedge clk);
		config_start <= 1'b0;
		repeat (3) @(negedge clk);
		`CHK("mode_kept", 3'h4, {mode_valid_ff, config_mode_ff})
		`CHK("mode_pu_off", 1'b0, mode_pullup_en_ff)
		power_cycle(1'b1);
		`CHK("mode_after", 3'h4, {mode_valid_ff, config_mode_ff})
	endtask
	// user requests raise float and set/reset ahead of any power-down
	task automatic float_case;
		@(posedge clk);
		user_float_req <= 1'b1;
		user_set_reset_req <= 1'b1;
		init_status_in <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("user_float", 2'h2, {global_output_float_ff, output_buf_en_ff})
		`CHK("user_setrst", 1'b1, global_set_reset_ff)
		`CHK("init_follow", 1'b0, init_status_ff)
		@(posedge clk);
		scan_extest <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK("extest_drive", 1'b0, global_output_float_ff)
		@(posedge clk);
		user_float_req <= 1'b0;
		user_set_reset_req <= 1'b0;
		scan_extest <= 1'b0;
		init_status_in <= 1'b1;
		repeat (2) @(negedge clk);
		`CHK("normal", 4'hf, {output_buf_en_ff, init_status_ff, done_seen_ff, scan_enable_ff})
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK("rst_en", 2'h3, {input_buf_en_ff, output_buf_en_ff})
		float_case();
		foreach (tbl[i]) mode_case(tbl[i]);
		keep_mode();
		end_of_test();
	end
	initial begin
		#50000;
		fails++;
		end_of_test();
	end
endmodule
bind pdc_power_down_ctrl pdc_monitor u_mon (.*);
`default_nettype wire
